/* hw/umir_top.sv */
`timescale 1ns/100ps
`include "umir_map.svh"

// Summary of operation
// - aux output one driven low while control bit 2 is set, else high.
// - aux output one high on master reset and throughout loop mode.
// - aux output two driven low while control bit 3 is set, else high.
// - aux output two high on master reset and throughout loop mode.
// - status bit 6 shows the present ring indicator state.
// - status bit 2 sets when ring input rose since last status read.
// - modem interrupt enabled and ring input rising raises the interrupt.
// - ring sensing keeps working while terminal-ready is inactive; no gating.
// - status bit 7 shows the present carrier detect state.
// - status bit 3 sets on any carrier detect change since last read.
// - carrier detect never affects the receiver.
// - modem interrupt enabled and carrier change raises the interrupt.
// - master reset halts serial activity until software re-enables it.
// - master reset clears modem control and its outputs go inactive.
// - master reset clears line status except both transmit-empty flags set.
// - interrupt output high while any enabled source is active.
// - interrupt output falls once the source is serviced or on reset.
module umir_top
    import umir_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_MASTER_RESET,
    input wire logic I_READ,
    input wire logic I_WRITE,
    input wire logic [4:0] I_ADDRESS,
    input wire logic [31:0] I_WRITEDATA,
    input wire logic [3:0] I_BYTEENABLE,
    output logic [31:0] O_READDATA,
    output logic O_WAITREQUEST,
    input wire logic I_RING_INDICATOR_IN_N,
    input wire logic I_CARRIER_DETECT_IN_N,
    input wire logic I_SERIAL_IN_LINE,
    input wire logic I_TX_SERIAL,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_DATA_VALID,
    input wire logic [3:0] I_RX_ERROR,
    input wire logic I_TX_HOLD_TAKEN,
    input wire logic I_TX_DONE,
    output logic O_AUX_OUTPUT_ONE_N,
    output logic O_AUX_OUTPUT_TWO_N,
    output logic O_DTR_N,
    output logic O_RTS_N,
    output logic O_INTERRUPT_REQUEST_OUT,
    output logic O_RX_SERIAL,
    output logic O_SERIAL_ENABLE,
    output logic [7:0] O_TX_DATA,
    output logic O_TX_LOAD
);

    // ------------------------------------------------------------------------
    // pin synchronisation and edge tracking
    // ------------------------------------------------------------------------
    logic [3:0] pins_sync;
    logic ri_sync;
    logic dcd_sync;
    logic sin_sync;
    logic mr_sync;
    umir_edge_t ri_edge;
    umir_edge_t dcd_edge;

    // ring, carrier, serial-in and master-reset pins each cross two flops before anything looks at them
    umir_sync #(
        .WIDTH(4),
        .INIT(`UMIR_PIN_RESET)
    ) u_sync (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_async({I_MASTER_RESET, I_SERIAL_IN_LINE, I_CARRIER_DETECT_IN_N,
            I_RING_INDICATOR_IN_N}),
        .o_sync(pins_sync)
    );

    assign ri_sync = pins_sync[0];
    assign dcd_sync = pins_sync[1];
    assign sin_sync = pins_sync[2];
    assign mr_sync = pins_sync[3];

    // ring tracking is never gated by terminal-ready
    umir_edge u_ri_edge (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_level(ri_sync),
        .o_edge(ri_edge)
    );

    umir_edge u_dcd_edge (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_level(dcd_sync),
        .o_edge(dcd_edge)
    );

    // ------------------------------------------------------------------------
    // reset combination
    // ------------------------------------------------------------------------
    logic clear_all;

    // master reset acts like a synchronous clear of registers and flags; the bus handshake, read data and edge trackers are not cleared
    assign clear_all = ~I_RESET_N | mr_sync;

    // ------------------------------------------------------------------------
    // avalon slave handshake
    // ------------------------------------------------------------------------
    umir_av_req_t req;
    umir_bus_state_t bus_state_reg;
    logic waitreq_reg;
    logic [31:0] readdata_reg;
    logic accept;
    logic rd_accept;
    logic wr_accept;
    logic [7:0] read_mux;

    assign req = '{read: I_READ, write: I_WRITE, addr: I_ADDRESS,
        wdata: I_WRITEDATA[7:0]};
    assign accept = (req.read | req.write) & ~waitreq_reg;
    assign rd_accept = accept & req.read;
    // registers are eight bits wide; only lane 0 carries them
    assign wr_accept = accept & req.write & I_BYTEENABLE[0];

    // fixed one wait cycle: decode in idle, answer in the next cycle
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESET_N)
        begin
            bus_state_reg <= UMIR_BUS_IDLE;
            waitreq_reg <= 1'b1;
        end
        else
        begin
            unique case (bus_state_reg)
                UMIR_BUS_IDLE:
                begin
                    if (req.read | req.write)
                    begin
                        bus_state_reg <= UMIR_BUS_ANSWER;
                        waitreq_reg <= 1'b0;
                    end
                end
                UMIR_BUS_ANSWER:
                begin
                    bus_state_reg <= UMIR_BUS_IDLE;
                    waitreq_reg <= 1'b1;
                end
            endcase
        end
    end

    // read data is captured on entry to the answer cycle and stands there
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESET_N)
        begin
            readdata_reg <= 32'h0;
        end
        else if (bus_state_reg == UMIR_BUS_IDLE && req.read)
        begin
            readdata_reg <= {24'h0, read_mux};
        end
        else if (bus_state_reg == UMIR_BUS_ANSWER)
        begin
            readdata_reg <= readdata_reg;
        end
        else
        begin
            readdata_reg <= 32'h0;
        end
    end

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    logic [3:0] ier_reg;
    umir_mcr_t mcr_reg;
    logic enable_reg;

    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            ier_reg <= `UMIR_IER_RESET;
        end
        else if (wr_accept && req.addr == `UMIR_OFS_IER)
        begin
            ier_reg <= req.wdata[3:0];
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            mcr_reg <= `UMIR_MCR_RESET;
        end
        else if (wr_accept && req.addr == `UMIR_OFS_MCR)
        begin
            mcr_reg <= req.wdata[4:0];
        end
    end

    // serial activity stays halted after master reset until re-enabled
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            enable_reg <= 1'b0;
        end
        else if (wr_accept && req.addr == `UMIR_OFS_CTRL)
        begin
            enable_reg <= req.wdata[`UMIR_CTRL_ENABLE];
        end
    end

    // ------------------------------------------------------------------------
    // line status flags
    // ------------------------------------------------------------------------
    logic dr_reg;
    logic [3:0] err_reg;
    logic tx_holding_empty_flag_reg;
    logic tx_fully_empty_flag_reg;
    logic [7:0] rx_data_reg;
    logic rd_lsr;
    logic rd_data;
    logic wr_data;

    assign rd_lsr = rd_accept && req.addr == `UMIR_OFS_LSR;
    assign rd_data = rd_accept && req.addr == `UMIR_OFS_DATA;
    assign wr_data = wr_accept && req.addr == `UMIR_OFS_DATA && enable_reg;

    // set wins over the clear in every flag below
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            dr_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end
        else if (I_RX_DATA_VALID && enable_reg)
        begin
            dr_reg <= 1'b1;
            rx_data_reg <= I_RX_DATA;
        end
        else if (rd_data)
        begin
            dr_reg <= 1'b0;
        end
    end

    // only error bits that were actually reported are cleared
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            err_reg <= `UMIR_ERR_RESET;
        end
        else
        begin
            err_reg <= (err_reg & ~({4{rd_lsr}}
                & readdata_reg[`UMIR_LSR_ERR_HI:`UMIR_LSR_ERR_LO]))
                | (I_RX_ERROR & {4{enable_reg}});
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            tx_holding_empty_flag_reg <= 1'b1;
            tx_fully_empty_flag_reg <= 1'b1;
        end
        else
        begin
            tx_holding_empty_flag_reg <= I_TX_HOLD_TAKEN | (tx_holding_empty_flag_reg & ~wr_data);
            tx_fully_empty_flag_reg <= I_TX_DONE | (tx_fully_empty_flag_reg & ~wr_data);
        end
    end

    // ------------------------------------------------------------------------
    // modem status change flags
    // ------------------------------------------------------------------------
    logic ring_trailing_edge_flag_reg;
    logic carrier_change_flag_reg;
    logic rd_msr;

    assign rd_msr = rd_accept && req.addr == `UMIR_OFS_MSR;

    // a read clears only what it returned, so a change in the answer
    // cycle survives to the next read
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            ring_trailing_edge_flag_reg <= 1'b0;
            carrier_change_flag_reg <= 1'b0;
        end
        else
        begin
            ring_trailing_edge_flag_reg <= ri_edge.rise
                | (ring_trailing_edge_flag_reg & ~(rd_msr & readdata_reg[`UMIR_MSR_RING_TRAILING_EDGE_FLAG]));
            carrier_change_flag_reg <= dcd_edge.rise | dcd_edge.fall
                | (carrier_change_flag_reg & ~(rd_msr & readdata_reg[`UMIR_MSR_CARRIER_CHANGE_FLAG]));
        end
    end

    // ------------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------------
    always_comb
    begin
        read_mux = 8'h00;
        unique case (req.addr)
            `UMIR_OFS_IER: read_mux = {4'h0, ier_reg};
            `UMIR_OFS_MCR: read_mux = {3'h0, mcr_reg};
            `UMIR_OFS_LSR:
            begin
                read_mux[`UMIR_LSR_DR] = dr_reg;
                read_mux[`UMIR_LSR_ERR_HI:`UMIR_LSR_ERR_LO] = err_reg;
                read_mux[`UMIR_LSR_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag_reg;
                read_mux[`UMIR_LSR_TX_FULLY_EMPTY_FLAG] = tx_fully_empty_flag_reg;
            end
            `UMIR_OFS_MSR:
            begin
                read_mux[`UMIR_MSR_RING_TRAILING_EDGE_FLAG] = ring_trailing_edge_flag_reg;
                read_mux[`UMIR_MSR_CARRIER_CHANGE_FLAG] = carrier_change_flag_reg;
                // pins are active low; a one means asserted
                read_mux[`UMIR_MSR_RI] = ~ri_edge.level;
                read_mux[`UMIR_MSR_DCD] = ~dcd_edge.level;
            end
            `UMIR_OFS_DATA: read_mux = rx_data_reg;
            `UMIR_OFS_CTRL: read_mux = {7'h00, enable_reg};
            default: read_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------------
    logic [3:0] irq_src;
    logic irq_reg;

    always_comb
    begin
        irq_src = 4'h0;
        irq_src[`UMIR_IER_RXAVAIL] = dr_reg;
        irq_src[`UMIR_IER_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag_reg;
        irq_src[`UMIR_IER_RXERR] = |err_reg;
        irq_src[`UMIR_IER_MODEM] = ring_trailing_edge_flag_reg | carrier_change_flag_reg;
    end

    // level output: falls when every enabled source is serviced, or on reset or master reset
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(irq_src & ier_reg);
        end
    end

    // ------------------------------------------------------------------------
    // modem outputs and serial path
    // ------------------------------------------------------------------------
    logic aux_output_one_n_reg;
    logic aux_output_two_n_reg;
    logic dtr_n_reg;
    logic rts_n_reg;
    logic rx_serial_reg;
    logic [7:0] tx_data_reg;
    logic tx_load_reg;

    // loop mode forces all modem outputs inactive whatever the bits hold
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            aux_output_one_n_reg <= 1'b1;
            aux_output_two_n_reg <= 1'b1;
            dtr_n_reg <= 1'b1;
            rts_n_reg <= 1'b1;
        end
        else
        begin
            aux_output_one_n_reg <= ~(mcr_reg.aux_output_one & ~mcr_reg.loop);
            aux_output_two_n_reg <= ~(mcr_reg.aux_output_two & ~mcr_reg.loop);
            dtr_n_reg <= ~(mcr_reg.dtr & ~mcr_reg.loop);
            rts_n_reg <= ~(mcr_reg.rts & ~mcr_reg.loop);
        end
    end

    // carrier detect takes no part in the receive path
    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            rx_serial_reg <= 1'b1;
        end
        else if (!enable_reg)
        begin
            rx_serial_reg <= 1'b1;
        end
        else if (mcr_reg.loop)
        begin
            rx_serial_reg <= I_TX_SERIAL;
        end
        else
        begin
            rx_serial_reg <= sin_sync;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (clear_all)
        begin
            tx_data_reg <= 8'h00;
            tx_load_reg <= 1'b0;
        end
        else
        begin
            tx_load_reg <= wr_data;
            if (wr_data)
            begin
                tx_data_reg <= req.wdata;
            end
        end
    end

    assign O_READDATA = readdata_reg;
    assign O_WAITREQUEST = waitreq_reg;
    assign O_AUX_OUTPUT_ONE_N = aux_output_one_n_reg;
    assign O_AUX_OUTPUT_TWO_N = aux_output_two_n_reg;
    assign O_DTR_N = dtr_n_reg;
    assign O_RTS_N = rts_n_reg;
    assign O_INTERRUPT_REQUEST_OUT = irq_reg;
    assign O_RX_SERIAL = rx_serial_reg;
    assign O_SERIAL_ENABLE = enable_reg;
    assign O_TX_DATA = tx_data_reg;
    assign O_TX_LOAD = tx_load_reg;

endmodule // umir_top

/* hw/umir_map.svh */
`ifndef UMIR_MAP_SVH
`define UMIR_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define UMIR_OFS_IER 5'h00
`define UMIR_OFS_MCR 5'h04
`define UMIR_OFS_LSR 5'h08
`define UMIR_OFS_MSR 5'h0c
`define UMIR_OFS_DATA 5'h10
`define UMIR_OFS_CTRL 5'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define UMIR_IER_RXAVAIL 0
`define UMIR_IER_TX_HOLDING_EMPTY_FLAG 1
`define UMIR_IER_RXERR 2
`define UMIR_IER_MODEM 3
`define UMIR_LSR_DR 0
`define UMIR_LSR_ERR_LO 1
`define UMIR_LSR_ERR_HI 4
`define UMIR_LSR_TX_HOLDING_EMPTY_FLAG 5
`define UMIR_LSR_TX_FULLY_EMPTY_FLAG 6
`define UMIR_MSR_RING_TRAILING_EDGE_FLAG 2
`define UMIR_MSR_CARRIER_CHANGE_FLAG 3
`define UMIR_MSR_RI 6
`define UMIR_MSR_DCD 7
`define UMIR_CTRL_ENABLE 0

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define UMIR_IER_RESET 4'h0
`define UMIR_MCR_RESET 5'h00
`define UMIR_ERR_RESET 4'h0
`define UMIR_SYNC_STAGES 2
`define UMIR_PIN_RESET 4'h7

`endif

/* hw/umir_pkg.sv */
package umir_pkg;

    typedef struct packed {
        logic loop;
        logic aux_output_two;
        logic aux_output_one;
        logic rts;
        logic dtr;
    } umir_mcr_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] addr;
        logic [7:0] wdata;
    } umir_av_req_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } umir_edge_t;

    typedef enum logic {
        UMIR_BUS_IDLE,
        UMIR_BUS_ANSWER
    } umir_bus_state_t;

endpackage

/* hw/umir_sync.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// two-stage synchroniser, one chain per bit
// ----------------------------------------------------------------------------
module umir_sync
    import umir_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_reg;
            logic sync_reg;
            // first stage feeds only the second stage
            always_ff @(posedge i_clk)
            begin
                if (!i_reset_n)
                begin
                    meta_reg <= INIT[g];
                    sync_reg <= INIT[g];
                end
                else
                begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule // umir_sync

/* hw/umir_edge.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// level and edge tracker for one synchronised input
// ----------------------------------------------------------------------------
module umir_edge
    import umir_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_level,
    output umir_edge_t o_edge
);

    logic prev_reg;
    logic primed_reg;
    umir_edge_t edge_reg;

    // first cycle after reset only loads; the synchroniser starts high, so a pin already low still shows as a fall
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            prev_reg <= 1'b1;
            primed_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= i_level;
            primed_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            edge_reg <= '{rise: 1'b0, fall: 1'b0, level: 1'b1};
        end
        else
        begin
            edge_reg.level <= i_level;
            edge_reg.rise <= primed_reg & ~prev_reg & i_level;
            edge_reg.fall <= primed_reg & prev_reg & ~i_level;
        end
    end

    assign o_edge = edge_reg;

endmodule // umir_edge

/* sim/umir_monitor.sv */
`timescale 1ns/100ps
`include "umir_map.svh"

module umir_monitor (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_MASTER_RESET,
    input wire logic I_READ,
    input wire logic I_WRITE,
    input wire logic [4:0] I_ADDRESS,
    input wire logic [31:0] I_WRITEDATA,
    input wire logic [3:0] I_BYTEENABLE,
    input wire logic [31:0] O_READDATA,
    input wire logic O_WAITREQUEST,
    input wire logic I_RING_INDICATOR_IN_N,
    input wire logic I_CARRIER_DETECT_IN_N,
    input wire logic O_AUX_OUTPUT_ONE_N,
    input wire logic O_AUX_OUTPUT_TWO_N,
    input wire logic O_INTERRUPT_REQUEST_OUT
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    logic ier_modem_reg;
    logic [3:0] up_reg;
    wire logic wr_ok = I_WRITE && !O_WAITREQUEST && I_BYTEENABLE[0];
    wire logic want_one = !(I_WRITEDATA[2] && !I_WRITEDATA[4]);
    wire logic want_two = !(I_WRITEDATA[3] && !I_WRITEDATA[4]);

    // shadow is cleared early on master reset: fewer triggers, never false ones
    always_ff @(posedge I_CLK)
        if (!I_RESET_N || I_MASTER_RESET)
            ier_modem_reg <= 1'b0;
        else if (wr_ok && I_ADDRESS == `UMIR_OFS_IER)
            ier_modem_reg <= I_WRITEDATA[3];

    // pin levels are trusted only once the sync chain has filled
    always_ff @(posedge I_CLK)
        if (!I_RESET_N)
            up_reg <= 4'h0;
        else if (up_reg != 4'hf)
            up_reg <= up_reg + 4'h1;

    sequence s_mcr_wr;
        wr_ok && I_ADDRESS == `UMIR_OFS_MCR && !I_MASTER_RESET;
    endsequence
    sequence s_msr_ans;
        I_READ && !O_WAITREQUEST && I_ADDRESS == `UMIR_OFS_MSR && up_reg == 4'hf;
    endsequence

    a_aux_one_map: assert property (s_mcr_wr
        |=> ##1 O_AUX_OUTPUT_ONE_N == $past(want_one, 2)) else $error("aux one level wrong");
    a_aux_two_map: assert property (s_mcr_wr
        |=> ##1 O_AUX_OUTPUT_TWO_N == $past(want_two, 2)) else $error("aux two level wrong");
    a_ring_level: assert property ($stable(I_RING_INDICATOR_IN_N)[*6] ##0 s_msr_ans
        |-> O_READDATA[6] == !I_RING_INDICATOR_IN_N) else $error("ring level bit wrong");
    a_carrier_level: assert property ($stable(I_CARRIER_DETECT_IN_N)[*6] ##0 s_msr_ans
        |-> O_READDATA[7] == !I_CARRIER_DETECT_IN_N) else $error("carrier level bit wrong");
    a_modem_irq: assert property (($rose(I_RING_INDICATOR_IN_N) ||
        $changed(I_CARRIER_DETECT_IN_N)) && ier_modem_reg && up_reg == 4'hf && !I_MASTER_RESET
        |-> ##[3:8] O_INTERRUPT_REQUEST_OUT) else $error("modem interrupt missing");
    a_irq_mreset: assert property (I_MASTER_RESET[*4] |-> !O_INTERRUPT_REQUEST_OUT)
        else $error("interrupt high in master reset");
    a_aux_mreset: assert property (I_MASTER_RESET[*4]
        |-> O_AUX_OUTPUT_ONE_N && O_AUX_OUTPUT_TWO_N) else $error("aux active in master reset");
    a_wait_one: assert property ((I_READ || I_WRITE) && O_WAITREQUEST
        |=> !O_WAITREQUEST ##1 O_WAITREQUEST) else $error("bus answer not one wait state");
endmodule // umir_monitor

bind umir_top umir_monitor i_mon (.I_CLK, .I_RESET_N, .I_MASTER_RESET, .I_READ, .I_WRITE,
    .I_ADDRESS, .I_WRITEDATA, .I_BYTEENABLE, .O_READDATA, .O_WAITREQUEST,
    .I_RING_INDICATOR_IN_N, .I_CARRIER_DETECT_IN_N, .O_AUX_OUTPUT_ONE_N,
    .O_AUX_OUTPUT_TWO_N, .O_INTERRUPT_REQUEST_OUT);

/* sim/umir_modem.sv */
`timescale 1ns/100ps

module umir_modem (
    input wire logic i_clk,
    output logic o_ring_n,
    output logic o_dcd_n,
    output logic o_sin
);
    // idle line sits at mark, which is the high level
    initial
    begin
        o_ring_n = 1'b1;
        o_dcd_n = 1'b1;
        o_sin = 1'b1;
    end

    task automatic drive(input logic r, input logic c, input logic s);
        @(posedge i_clk);
        o_ring_n <= r;
        o_dcd_n <= c;
        o_sin <= s;
    endtask
endmodule // umir_modem

/* sim/tb_top.sv */
`timescale 1ns/100ps
`include "umir_map.svh"

module tb_top;
    logic I_CLK, I_RESET_N, I_MASTER_RESET, I_READ, I_WRITE, I_TX_SERIAL, I_RX_DATA_VALID;
    logic [4:0] I_ADDRESS;
    logic [31:0] I_WRITEDATA;
    logic [3:0] I_BYTEENABLE, I_RX_ERROR, er;
    wire logic [31:0] O_READDATA;
    wire logic [7:0] O_TX_DATA;
    wire logic O_DTR_N, O_RTS_N, O_TX_LOAD;
    wire logic O_WAITREQUEST, O_AUX_OUTPUT_ONE_N, O_AUX_OUTPUT_TWO_N;
    wire logic O_INTERRUPT_REQUEST_OUT, O_RX_SERIAL, O_SERIAL_ENABLE;
    wire logic I_RING_INDICATOR_IN_N, I_CARRIER_DETECT_IN_N, I_SERIAL_IN_LINE;
    int fails = 0;
    int compares = 0;
    logic ri, dcd, ring_trailing_edge_flag, carrier_change_flag, e;
    logic [31:0] q;

    umir_top i_dut (.I_CLK, .I_RESET_N, .I_MASTER_RESET, .I_READ, .I_WRITE, .I_ADDRESS,
        .I_WRITEDATA, .I_BYTEENABLE, .O_READDATA, .O_WAITREQUEST, .I_RING_INDICATOR_IN_N,
        .I_CARRIER_DETECT_IN_N, .I_SERIAL_IN_LINE, .I_TX_SERIAL, .I_RX_DATA(8'h00),
        .I_RX_DATA_VALID, .I_RX_ERROR, .I_TX_HOLD_TAKEN(1'b0), .I_TX_DONE(1'b0),
        .O_AUX_OUTPUT_ONE_N, .O_AUX_OUTPUT_TWO_N, .O_DTR_N, .O_RTS_N,
        .O_INTERRUPT_REQUEST_OUT, .O_RX_SERIAL, .O_SERIAL_ENABLE, .O_TX_DATA, .O_TX_LOAD);
    umir_modem i_modem (.i_clk(I_CLK), .o_ring_n(I_RING_INDICATOR_IN_N),
        .o_dcd_n(I_CARRIER_DETECT_IN_N), .o_sin(I_SERIAL_IN_LINE));

    initial
    begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end

    // ----
    // bus, compare and closing tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        I_READ <= !wr;
        I_WRITE <= wr;
        I_ADDRESS <= a;
        I_WRITEDATA <= {24'($urandom()), d};
        I_BYTEENABLE <= 4'($urandom()) | 4'h1;
        do
        begin
            @(posedge I_CLK);
        end while (O_WAITREQUEST !== 1'b0);
        q = O_READDATA;
        I_READ <= 1'b0;
        I_WRITE <= 1'b0;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            fails++;
            $display("unexpected %0t register %h, want %h", $time, g, x);
        end
    endtask

    task automatic chk_pin(input logic g, input logic x);
        compares++;
        if (g !== x)
        begin
            fails++;
            $display("unexpected %0t pin %b, want %b", $time, g, x);
        end
    endtask

    task automatic test_done;
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // model keeps pin levels and sticky change flags as the rules state them
    task automatic set_modem(input logic r, input logic c);
        if (!ri && r)
            ring_trailing_edge_flag = 1'b1;
        if (dcd !== c)
            carrier_change_flag = 1'b1;
        ri = r;
        dcd = c;
        i_modem.drive(r, c, 1'b1);
        tick(8);
    endtask

    task automatic rd_msr;
        bus(1'b0, `UMIR_OFS_MSR, 8'h00);
        chk_reg(q, {24'h0, !dcd, !ri, 2'h0, carrier_change_flag, ring_trailing_edge_flag, 2'h0});
        ring_trailing_edge_flag = 1'b0;
        carrier_change_flag = 1'b0;
    endtask

    initial
    begin
        repeat (5000) @(posedge I_CLK);
        fails++;
        test_done;
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        {I_RESET_N, I_MASTER_RESET, I_READ, I_WRITE, ring_trailing_edge_flag, carrier_change_flag} = 6'h0;
        {I_ADDRESS, I_WRITEDATA, I_BYTEENABLE, I_RX_ERROR, I_RX_DATA_VALID} = 46'h0;
        {I_TX_SERIAL, ri, dcd} = 3'h7;
        void'($urandom(32'h61b17b16));
        repeat (2) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        tick(4);
        for (int i = 0; i < 32; i++)
        begin
            bus(1'b1, `UMIR_OFS_MCR, {3'($urandom()), 5'(i)});
            tick(1);
            chk_pin(O_AUX_OUTPUT_ONE_N, !(i[2] && !i[4]));
            chk_pin(O_AUX_OUTPUT_TWO_N, !(i[3] && !i[4]));
        end
        bus(1'b1, `UMIR_OFS_CTRL, 8'h01);
        I_TX_SERIAL <= 1'b0;
        i_modem.drive(1'b1, 1'b1, 1'b1);
        tick(6);
        chk_pin(O_RX_SERIAL, 1'b0);
        chk_pin(O_SERIAL_ENABLE, 1'b1);
        bus(1'b1, `UMIR_OFS_MCR, 8'h00);
        I_TX_SERIAL <= 1'b1;
        i_modem.drive(1'b1, 1'b1, 1'b0);
        tick(6);
        chk_pin(O_RX_SERIAL, 1'b0);
        i_modem.drive(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            e = (i < 2) || 1'($urandom());
            bus(1'b1, `UMIR_OFS_IER, {4'h0, e, 3'h0});
            set_modem((i < 2) ? i[0] : 1'($urandom()), 1'($urandom()));
            chk_pin(O_INTERRUPT_REQUEST_OUT, e && (ring_trailing_edge_flag || carrier_change_flag));
            rd_msr;
            tick(2);
            chk_pin(O_INTERRUPT_REQUEST_OUT, 1'b0);
        end
        bus(1'b1, `UMIR_OFS_IER, 8'h02);
        bus(1'b1, `UMIR_OFS_MCR, 8'h0f);
        tick(3);
        chk_pin(O_INTERRUPT_REQUEST_OUT, 1'b1);
        // dirty the line status so the master reset clear below is visible
        er = 4'($urandom()) | 4'h1;
        bus(1'b1, `UMIR_OFS_DATA, {4'h0, er});
        I_RX_DATA_VALID <= 1'b1;
        I_RX_ERROR <= er;
        #1;
        chk_pin(O_TX_LOAD, 1'b1);
        chk_reg({24'h0, O_TX_DATA}, {28'h0, er});
        @(posedge I_CLK);
        {I_RX_DATA_VALID, I_RX_ERROR} <= 5'h0;
        bus(1'b0, `UMIR_OFS_LSR, 8'h00);
        chk_reg(q, {27'h0, er, 1'b1});
        @(posedge I_CLK);
        I_MASTER_RESET <= 1'b1;
        set_modem(1'b0, !dcd);
        chk_pin(O_INTERRUPT_REQUEST_OUT, 1'b0);
        chk_pin(O_AUX_OUTPUT_ONE_N, 1'b1);
        chk_pin(O_AUX_OUTPUT_TWO_N, 1'b1);
        chk_pin(O_DTR_N & O_RTS_N, 1'b1);
        chk_pin(O_SERIAL_ENABLE, 1'b0);
        chk_pin(O_RX_SERIAL, 1'b1);
        @(posedge I_CLK);
        I_MASTER_RESET <= 1'b0;
        tick(4);
        ring_trailing_edge_flag = 1'b0;
        carrier_change_flag = 1'b0;
        bus(1'b0, `UMIR_OFS_LSR, 8'h00);
        chk_reg(q, 32'h00000060);
        chk_pin(O_INTERRUPT_REQUEST_OUT, 1'b0);
        rd_msr;
        test_done;
    end
endmodule // tb_top
